// File: sadc_pkg.sv
// Functional notes
// - Mode bit 3 of mode/status nibble: 0 continuous, 1 single; resets 0.
// - Continuous mode resolves eight bits by successive approximation, MSB first.
// - Single mode drives data register into DAC for one comparison.
// - Two-bit channel field picks analog input 0 to 3; resets 0.
// - STOP clears the data register to zero.
// - HALT never interrupts a running conversion or comparison.
// - STOP aborts, cuts reference current, stays idle until restarted.
// - Continuous mode: reference current on from start until done sets.
// - Single mode: reference current on from start until compare flag written.
// - Comparator 1 when input above DAC; stored to bit or compare flag.
// - Done flag sets at continuous end, clears on any start, resets 0.
// - Compare flag valid from third instruction after start until next start.
// - Compare flag follows intermediate decisions in continuous mode.
// - Writing 1 to start bit starts operation; bit always reads 0.
// - Single mode data register write starts a comparison by itself.
// - Data register at 04h; buffer write loads only low eight bits.
// - Register read puts data in low byte; upper buffer byte unchanged.
// - Sample-hold stays in hold during the whole conversion.
// - Conversion within 25 instruction times; three per bit, MSB first.
// - With mode bit 0, data register writes are ignored.
// - Compare flag cleared by reset and by a data register write in single mode.
package sadc_pkg;
  localparam logic [7:0] DATA_ADDR   = 8'h04;
  localparam logic [7:0] START_ADDR  = 8'h20;
  localparam logic [7:0] MODE_ADDR   = 8'h21;
  localparam logic [7:0] CHAN_ADDR   = 8'h22;
  localparam int         START_BIT   = 0;
  localparam int         DONE_BIT    = 0;
  localparam int         CMP_BIT     = 1;
  localparam int         MODE_BIT    = 3;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [1:0] CHAN_RST    = 2'h0;
  localparam int         RES_BITS    = 8;
  // Instruction time in core clocks, and instruction times per bit
  localparam int         INSTR_CYC   = 4;
  localparam int         INSTR_PER_BIT = 3;
  localparam int         CMP_INSTR   = 2;
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_CMP  = 2'b10
  } sadc_state_t;
endpackage : sadc_pkg

// File: sadc_tick_if.sv
`timescale 1ns/10ps
// Instruction-time tick between divider and sequencer
interface sadc_tick_if;
  logic clr;
  logic tick;
  modport src (input clr, output tick);
  modport dst (output clr, input tick);
endinterface : sadc_tick_if

// File: sadc_tick.sv
`timescale 1ns/10ps
// Divider giving one pulse per instruction time, restartable
module sadc_tick #(
  parameter int DIV = sadc_pkg::INSTR_CYC
) (
  // Clock and reset
  input wire logic   core_clk,
  input wire logic   rst_b,
  // Tick carrier
  sadc_tick_if.src   tk
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  initial begin
    if (DIV < 1 || DIV > 255) $error("sadc_tick: DIV out of range");
  end
  // Count down, reload on clear or wrap
  always_comb begin
    if (tk.clr || cnt_r == 8'h00) begin
      cnt_nxt = 8'(DIV - 1);
    end else begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign tk.tick = !tk.clr && (cnt_r == 8'h00);
endmodule : sadc_tick

// File: sadc_ctrl.sv
`timescale 1ns/10ps
// Successive-approximation converter control
module sadc_ctrl #(
  parameter int INSTR_CYC = sadc_pkg::INSTR_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Control nibble access
  input  wire logic [7:0]  ctl_addr,
  input  wire logic        ctl_wr,
  input  wire logic [3:0]  ctl_wdata,
  output logic      [3:0]  ctl_rdata,
  // Data register transfer
  input  wire logic        peripheral_write_instr,
  input  wire logic        peripheral_read_instr,
  input  wire logic [7:0]  per_addr,
  input  wire logic [15:0] transfer_buffer,
  output logic      [15:0] transfer_buffer_rd,
  // Power modes
  input  wire logic        halt_exec,
  input  wire logic        stop_exec,
  // Analog front end
  input  wire logic        cmp_in,
  output logic      [7:0]  dac_code,
  output logic             ref_cur_en,
  output logic             sh_hold,
  output logic      [1:0]  chan_sel
);

  // Instruction-time tick carrier between divider and sequencer
  sadc_tick_if tk ();

  // Refuse timing figures that the 8-bit divider or the two-bit phase counter cannot hold, and any result width but 8 bits
  if (INSTR_CYC < 1 || INSTR_CYC > 255) begin : g_bad_cyc
    $error("sadc_ctrl: INSTR_CYC out of range");
  end
  if (sadc_pkg::INSTR_PER_BIT < 1 || sadc_pkg::INSTR_PER_BIT > 4)
  begin : g_bad_bit
    $error("sadc_ctrl: INSTR_PER_BIT out of range");
  end
  if (sadc_pkg::CMP_INSTR < 1 || sadc_pkg::CMP_INSTR > 4) begin : g_bad_cmp
    $error("sadc_ctrl: CMP_INSTR out of range");
  end
  if (sadc_pkg::RES_BITS != 8) begin : g_bad_res
    $error("sadc_ctrl: only an 8-bit result is served");
  end

  // Last phase index of a bit and of a single comparison
  localparam logic [1:0] BIT_LAST = 2'(sadc_pkg::INSTR_PER_BIT - 1);
  localparam logic [1:0] CMP_LAST = 2'(sadc_pkg::CMP_INSTR - 1);

  // Sequencer state
  sadc_pkg::sadc_state_t state_r;
  sadc_pkg::sadc_state_t state_nxt;
  logic [7:0]            data_r;
  logic [7:0]            data_nxt;
  logic [7:0]            trial_r;
  logic [7:0]            trial_nxt;
  logic [1:0]            phase_r;
  logic [1:0]            phase_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic                  cmp_r;
  logic                  cmp_nxt;

  // Control nibble state
  logic                  mode_r;
  logic                  mode_nxt;
  logic [1:0]            chan_r;
  logic [1:0]            chan_nxt;

  // Read path state
  logic [3:0]            rdata_r;
  logic [3:0]            rdata_nxt;
  logic [15:0]           tbrd_r;
  logic [15:0]           tbrd_nxt;

  // Decoded requests
  logic                  start_req;
  logic                  mode_wr;
  logic                  chan_wr;
  logic                  data_wr;
  logic                  data_rd;
  logic                  go_conv;
  logic                  go_cmp;

  // Divider that paces the sequencer one instruction time per tick
  sadc_tick #(
    .DIV (INSTR_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tk       (tk.src)
  );

  // Request decode from the control nibble and transfer strobes
  assign start_req = ctl_wr && (ctl_addr == sadc_pkg::START_ADDR)
                     && ctl_wdata[sadc_pkg::START_BIT];
  assign mode_wr   = ctl_wr && (ctl_addr == sadc_pkg::MODE_ADDR);
  assign chan_wr   = ctl_wr && (ctl_addr == sadc_pkg::CHAN_ADDR);
  assign data_wr   = peripheral_write_instr
                     && (per_addr == sadc_pkg::DATA_ADDR);
  assign data_rd   = peripheral_read_instr
                     && (per_addr == sadc_pkg::DATA_ADDR);

  // Start of an operation; STOP always wins over a start
  assign go_conv = start_req && !mode_r && !stop_exec;
  assign go_cmp  = (start_req || data_wr) && mode_r
                   && !stop_exec;

  // Divider restarts with every operation so each bit gets full time
  assign tk.clr = go_conv || go_cmp;

  // Sequencer next state: conversion, single compare, stop
  // HALT is deliberately not decoded here, so an operation runs on
  always_comb begin
    state_nxt = state_r;
    data_nxt  = data_r;
    trial_nxt = trial_r;
    phase_nxt = phase_r;
    done_nxt  = done_r;
    cmp_nxt   = cmp_r;
    if (stop_exec) begin
      // Abort, cut reference current, clear the data register
      state_nxt = sadc_pkg::SADC_IDLE;
      data_nxt  = 8'h00;
      trial_nxt = 8'h00;
      phase_nxt = 2'h0;
    end else if (go_conv) begin
      // First trial: most significant bit set, rest cleared
      state_nxt = sadc_pkg::SADC_CONV;
      data_nxt  = 8'h80;
      trial_nxt = 8'h80;
      phase_nxt = 2'h0;
      done_nxt  = 1'b0;
    end else if (go_cmp) begin
      // Single compare of the data register against the input
      state_nxt = sadc_pkg::SADC_CMP;
      phase_nxt = 2'h0;
      done_nxt  = 1'b0;
      if (data_wr) begin
        data_nxt = transfer_buffer[7:0];
        cmp_nxt  = 1'b0;
      end
    end else begin
      case (state_r)
        sadc_pkg::SADC_IDLE: begin
          // Data writes land only in single mode
          phase_nxt = 2'h0;
        end
        sadc_pkg::SADC_CONV: begin
          if (tk.tick) begin
            if (phase_r == BIT_LAST) begin
              // Decision: keep trial bit if input above code
              cmp_nxt = cmp_in;
              if (!cmp_in) begin
                data_nxt = data_r & ~trial_r;
              end
              phase_nxt = 2'h0;
              trial_nxt = trial_r >> 1;
              if (trial_r == 8'h01) begin
                state_nxt = sadc_pkg::SADC_IDLE;
                done_nxt  = 1'b1;
              end else begin
                // Next trial bit on top of decided bits
                data_nxt = (cmp_in ? data_r : (data_r & ~trial_r))
                           | (trial_r >> 1);
              end
            end else begin
              phase_nxt = phase_r + 2'h1;
            end
          end
        end
        sadc_pkg::SADC_CMP: begin
          if (tk.tick) begin
            if (phase_r == CMP_LAST) begin
              cmp_nxt   = cmp_in;
              state_nxt = sadc_pkg::SADC_IDLE;
              phase_nxt = 2'h0;
            end else begin
              phase_nxt = phase_r + 2'h1;
            end
          end
        end
        default: begin
          state_nxt = sadc_pkg::SADC_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= sadc_pkg::SADC_IDLE;
      data_r  <= sadc_pkg::DATA_RST;
      trial_r <= 8'h00;
      phase_r <= 2'h0;
      done_r  <= 1'b0;
      cmp_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      data_r  <= data_nxt;
      trial_r <= trial_nxt;
      phase_r <= phase_nxt;
      done_r  <= done_nxt;
      cmp_r   <= cmp_nxt;
    end
  end

  // Control nibble next values: mode bit and channel field
  always_comb begin
    mode_nxt = mode_r;
    chan_nxt = chan_r;
    if (mode_wr) begin
      mode_nxt = ctl_wdata[sadc_pkg::MODE_BIT];
    end
    if (chan_wr) begin
      chan_nxt = ctl_wdata[1:0];
    end
  end

  // Control nibble registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= 1'b0;
      chan_r <= sadc_pkg::CHAN_RST;
    end else begin
      mode_r <= mode_nxt;
      chan_r <= chan_nxt;
    end
  end

  // Read path next values: nibble mux and buffer merge
  always_comb begin
    case (ctl_addr)
      sadc_pkg::START_ADDR: begin
        rdata_nxt = 4'h0;
      end
      sadc_pkg::MODE_ADDR: begin
        rdata_nxt = {mode_r, 1'b0, cmp_r, done_r};
      end
      sadc_pkg::CHAN_ADDR: begin
        rdata_nxt = {2'b00, chan_r};
      end
      default: begin
        rdata_nxt = 4'h0;
      end
    endcase
    if (data_rd) begin
      // Upper buffer byte passes through untouched
      tbrd_nxt = {transfer_buffer[15:8], data_r};
    end else begin
      tbrd_nxt = transfer_buffer;
    end
  end

  // Read path registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 4'h0;
      tbrd_r  <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
      tbrd_r  <= tbrd_nxt;
    end
  end

  // Outputs; reference current and hold follow any busy state
  assign dac_code           = data_r;
  assign ref_cur_en         = (state_r != sadc_pkg::SADC_IDLE);
  assign sh_hold            = (state_r != sadc_pkg::SADC_IDLE);
  assign chan_sel           = chan_r;
  assign ctl_rdata          = rdata_r;
  assign transfer_buffer_rd = tbrd_r;

endmodule : sadc_ctrl

// File: sadc_front.sv
`timescale 1ns/10ps
// Comparator front end: input level against D/A code, per channel
module sadc_front(input wire logic [1:0] chan_sel, input wire logic [7:0] dac_code,
  input wire logic [7:0] ain [4], output logic cmp_in);
  assign cmp_in = ain[chan_sel] > dac_code;
endmodule : sadc_front

// File: sadc_ctrl_sva.sv
`timescale 1ns/10ps
// Port-level checks of the converter control
module sadc_ctrl_sva(input wire logic core_clk, rst_b, ctl_wr, stop_exec,
  input wire logic ref_cur_en, sh_hold, peripheral_read_instr,
  input wire logic [7:0] ctl_addr, per_addr, dac_code,
  input wire logic [3:0] ctl_wdata, ctl_rdata, input wire logic [1:0] chan_sel,
  input wire logic [15:0] transfer_buffer, transfer_buffer_rd);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_stop_ref_off: assert property (stop_exec |=> !ref_cur_en) else $error("ref on after stop");
  a_stop_clear: assert property (stop_exec |=> dac_code == 8'h00) else $error("data kept after stop");
  a_start_ref_on: assert property (ctl_wr && ctl_addr == 8'h20 && ctl_wdata[0] && !stop_exec |-> ##[1:2] ref_cur_en) else $error("no ref on start");
  a_conv_bound: assert property ($rose(ref_cur_en) |-> ##[1:120] !ref_cur_en) else $error("conversion too long");
  a_hold_during: assert property (ref_cur_en && $past(ref_cur_en) |-> sh_hold) else $error("hold dropped");
  a_start_reads0: assert property (ctl_addr == 8'h20 |=> !ctl_rdata[0]) else $error("start bit reads 1");
  a_chan_follow: assert property (ctl_wr && ctl_addr == 8'h22 |=> chan_sel == $past(ctl_wdata[1:0])) else $error("channel not taken");
  a_upper_keep: assert property (peripheral_read_instr && per_addr == 8'h04 |=> transfer_buffer_rd[15:8] == $past(transfer_buffer[15:8])) else $error("upper byte changed");
  c_conv_end: cover property ($fell(ref_cur_en));
  c_stop: cover property (stop_exec);
  c_read: cover property (peripheral_read_instr);
endmodule : sadc_ctrl_sva

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic core_clk = 0, rst_b = 0, ctl_wr = 0, pw = 0, pr = 0, halt_exec = 0, stop_exec = 0, cmp_in, ref_cur_en, sh_hold;
  logic [7:0] ctl_addr = 0, per_addr = 0, dac_code, ain [4];
  logic [3:0] ctl_wdata = 0, ctl_rdata;
  logic [15:0] tb = 0, tb_rd;
  logic [1:0] chan_sel;
  int n_mismatch = 0, checked = 0, seed = 83389, e;
  initial forever #10 core_clk = ~core_clk;
  sadc_ctrl uut(.*, .peripheral_write_instr(pw), .peripheral_read_instr(pr), .transfer_buffer(tb), .transfer_buffer_rd(tb_rd));
  sadc_front fe(.*);
  task automatic chk(string s, logic [7:0] x, y); checked++;
    if (x !== y) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", s, x, y); end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [3:0] d); @(posedge core_clk) begin ctl_addr <= a; ctl_wdata <= d; ctl_wr <= 1; end
    @(posedge core_clk) ctl_wr <= 0;
  endtask : wr
  task automatic rd(logic [7:0] a); @(posedge core_clk) ctl_addr <= a; @(posedge core_clk) #1;
  endtask : rd
  // Read data register through the buffer with random upper byte
  task automatic getd(int x); @(posedge core_clk) begin per_addr <= 8'h04; pr <= 1; tb <= 16'($random(seed)); end
    @(posedge core_clk) #1; chk("data", x, tb_rd[7:0]);
    chk("upper", tb[15:8], tb_rd[15:8]);
    @(posedge core_clk) pr <= 0;
  endtask : getd
  task report_and_stop; $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed"); else $display("Some tests failed"); $finish;
  endtask : report_and_stop
  // Watchdog against a hung handshake
  initial begin #400000; n_mismatch++; report_and_stop; end
  // Per channel: full conversion, single compare, then stop
  initial begin
    foreach (ain[i]) ain[i] = 8'($random(seed));
    repeat (16) @(posedge core_clk); rst_b <= 1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h22, c); wr(8'h21, 4'h0); halt_exec <= c[0]; wr(8'h20, 4'h1);
      repeat (200) begin rd(8'h21); if (ctl_rdata[0] === 1'b1) break; end
      chk("done", 1, ctl_rdata[0]);
      e = ain[c] ? ain[c] - 1 : 0; getd(e);
      wr(8'h21, 4'h8); @(posedge core_clk) begin tb <= 16'($random(seed)); pw <= 1; end
      @(posedge core_clk) pw <= 0; repeat (16) @(posedge core_clk); rd(8'h21);
      chk("cmp", ain[c] > tb[7:0], ctl_rdata[1]);
      @(posedge core_clk) stop_exec <= 1; @(posedge core_clk) stop_exec <= 0; getd(0);
    end
    report_and_stop;
  end
endmodule : testbench
bind sadc_ctrl sadc_ctrl_sva chk_i(.*);
